// file: src/slp_load_port.sv
// Serial register load port with an AHB-Lite view of its registers.
// Assumes sclk stands still while load_strobe rises, so the shift word
// is stable when the hclk side copies it.
//
// How it works
// - Low three bits select; upper bits are contents.
// - Sample data on sclk rise into 24 bits.
// - Strobe rise copies word into selected register.
// - Monitor shows reference or lock, register chosen.
// - Select pin high with power bit set powers synth, feeds mixer.
// - Select pin low powers down, routes external LO.
// - Serial power bit must also be set for synth mode.
// - LO pins output only with select, power, drive.
`timescale 1ns/10ps
`include "slp_params.svh"

module slp_load_port (
	input  wire logic              hclk,          // Bus clock, 125 MHz.
	input  wire logic              hresetn,       // Async reset, low.
	input  wire logic              hsel,          // Slave select.
	input  wire logic [7:0]        haddr,         // Byte address.
	input  wire logic [1:0]        htrans,        // Transfer type.
	input  wire logic              hwrite,        // Write when high.
	input  wire logic [2:0]        hsize,         // Word only.
	input  wire logic              hready,        // Bus ready in.
	input  wire logic [31:0]       hwdata,        // Write data.
	output logic      [31:0]       hrdata,        // Read data.
	output logic                   hreadyout,     // Always ready.
	output logic                   hresp,         // Always OKAY.
	input  wire logic              sclk,          // Serial clock.
	input  wire logic              sdata,         // Serial data.
	input  wire logic              load_strobe,   // Load on rise.
	input  wire logic              synth_select,  // Synth select pin.
	input  wire logic              lo_output_driver_pin, // Drive pin.
	input  wire logic              ref_signal,    // Reference level.
	input  wire logic              lock_detect,   // Lock level.
	output logic                   selectable_monitor_out, // Monitor.
	output slp_pkg::slp_lo_t       lo_ctl         // LO path drive.
);
	import slp_pkg::*;

	// ****************************************************************
	// Serial clock domain
	// ****************************************************************
	logic [`SLP_WORD_BITS-1:0] shift_q;
	logic [`SLP_WORD_BITS-1:0] next_shift_q;

	// Oldest bit falls off the top, so only the last 24 count.
	always_comb begin
		next_shift_q = {shift_q[`SLP_WORD_BITS-2:0], sdata};
	end

	always_ff @(posedge sclk or negedge hresetn) begin
		if (!hresetn) begin
			shift_q <= '0;
		end else begin
			shift_q <= next_shift_q;
		end
	end

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	localparam int NSYNC = 5;
	logic [NSYNC-1:0] pin_raw;
	logic [NSYNC-1:0] sync1;
	logic [NSYNC-1:0] sync2;
	logic             strobe_d;

	// First stage feeds only the second one.
	assign pin_raw = {load_strobe, synth_select, lo_output_driver_pin,
		ref_signal, lock_detect};

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync1    <= '0;
			sync2    <= '0;
			strobe_d <= 1'b0;
		end else begin
			sync1    <= pin_raw;
			sync2    <= sync1;
			strobe_d <= sync2[4];
		end
	end

	logic strobe_s;
	logic sel_s;
	logic drvpin_s;
	logic ref_s;
	logic lock_s;
	logic strobe_rise;
	assign strobe_s    = sync2[4];
	assign sel_s       = sync2[3];
	assign drvpin_s    = sync2[2];
	assign ref_s       = sync2[1];
	assign lock_s      = sync2[0];
	assign strobe_rise = strobe_s & ~strobe_d;

	// ****************************************************************
	// Stored registers and control
	// ****************************************************************
	slp_data_t      regs [`SLP_NUM_REGS];
	slp_data_t      next_regs [`SLP_NUM_REGS];
	logic [31:0]    ctrl;
	logic [31:0]    next_ctrl;
	logic [15:0]    load_count;
	logic [15:0]    next_load_count;
	logic [2:0]     load_idx;
	logic           load_en;

	// The word is quasi-static here: sclk is idle while the strobe is
	// high, so copying it without a second crossing is safe.
	assign load_idx = shift_q[`SLP_CTRL_BITS-1:0];
	assign load_en  = strobe_rise & ctrl[0];

	// Bus address phase held for a one-cycle data phase.
	logic       wr_pend;
	logic [7:0] wr_addr;
	logic       next_wr_pend;
	logic [7:0] next_wr_addr;
	logic [31:0] next_hrdata;
	logic       addr_ok;

	assign addr_ok = hsel & hready & (htrans == `SLP_HTRANS_NONSEQ);

	// Load and write updates; a serial load never takes ctrl, the only register a bus write sets.
	always_comb begin
		for (int i = 0; i < `SLP_NUM_REGS; i++) begin
			next_regs[i] = regs[i];
		end
		next_ctrl       = ctrl;
		next_load_count = load_count;
		if (load_en) begin
			next_regs[load_idx] = shift_q[`SLP_WORD_BITS-1:`SLP_CTRL_BITS];
			next_load_count     = load_count + 16'h0001;
		end
		if (wr_pend && wr_addr == `SLP_ADDR_CTRL) begin
			next_ctrl = hwdata;
		end
	end

	// Bus response: zero wait, reads prepared in the address phase.
	always_comb begin
		next_wr_pend = addr_ok & hwrite;
		next_wr_addr = haddr;
		next_hrdata  = hrdata;
		if (addr_ok && !hwrite) begin
			next_hrdata = 32'h00000000;
			if (haddr < `SLP_ADDR_STATUS && haddr[1:0] == 2'h0) begin
				next_hrdata = {11'h000, regs[haddr[4:2]]};
			end else if (haddr == `SLP_ADDR_STATUS) begin
				// Bits 20:18 LO drive, 17 select, 16 drive pin, 15:0 count.
				next_hrdata = {11'h000, lo_ctl, sel_s, drvpin_s,
					load_count};
			end else if (haddr == `SLP_ADDR_CTRL) begin
				next_hrdata = ctrl;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < `SLP_NUM_REGS; i++) begin
				regs[i] <= (i == 5) ? `SLP_REG5_RESET : `SLP_REGX_RESET;
			end
			ctrl       <= `SLP_CTRL_RESET;
			load_count <= 16'h0000;
			wr_pend    <= 1'b0;
			wr_addr    <= 8'h00;
			hrdata     <= 32'h00000000;
		end else begin
			regs       <= next_regs;
			ctrl       <= next_ctrl;
			load_count <= next_load_count;
			wr_pend    <= next_wr_pend;
			wr_addr    <= next_wr_addr;
			hrdata     <= next_hrdata;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// ****************************************************************
	// LO path and monitor
	// ****************************************************************
	logic    pwr_bit;
	logic    drv_bit;
	logic    mon_sel;
	slp_lo_t next_lo;
	logic    next_mon;

	assign pwr_bit = regs[`SLP_PWR_REG][`SLP_PWR_BIT];
	assign drv_bit = regs[`SLP_PWR_REG][`SLP_DRV_BIT];
	assign mon_sel = regs[`SLP_MON_REG][`SLP_MON_BIT];

	// The pin and the serial power bit must both agree to run the synth.
	always_comb begin
		next_lo.synth_power = sel_s & pwr_bit;
		next_lo.lo_internal = sel_s & pwr_bit;
		next_lo.lo_port_oe  = sel_s & pwr_bit & (drvpin_s | drv_bit);
		next_mon            = mon_sel ? lock_s : ref_s;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lo_ctl                 <= '0;
			selectable_monitor_out <= 1'b0;
		end else begin
			lo_ctl                 <= next_lo;
			selectable_monitor_out <= next_mon;
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	sequence seq_strobe_rise;
		strobe_s && !strobe_d && ctrl[0];
	endsequence

	a_shift_newest: assert property (@(posedge sclk) disable iff (!hresetn)
		##1 shift_q[0] == $past(sdata) &&
		shift_q[23:1] == $past(shift_q[22:0]))
		else $error("shift register did not take the sampled bit");

	a_load_target: assert property (@(posedge hclk) disable iff (!hresetn)
		seq_strobe_rise |=> regs[$past(load_idx)] == $past(shift_q[23:3]))
		else $error("load did not reach the selected register");

	a_load_disabled: assert property (@(posedge hclk) disable iff (!hresetn)
		(strobe_rise && !ctrl[0]) |=> load_count == $past(load_count))
		else $error("load happened while loads were disabled");

	a_mon_select: assert property (@(posedge hclk) disable iff (!hresetn)
		##1 selectable_monitor_out == $past(mon_sel ? lock_s : ref_s))
		else $error("monitor output shows the wrong source");

	a_synth_off: assert property (@(posedge hclk) disable iff (!hresetn)
		!sel_s |=> !lo_ctl.synth_power && !lo_ctl.lo_internal)
		else $error("synth left on with select pin low");

	a_synth_on: assert property (@(posedge hclk) disable iff (!hresetn)
		(sel_s && pwr_bit) |=> lo_ctl.synth_power && lo_ctl.lo_internal)
		else $error("synth not on with select pin high");

	a_spi_mode: assert property (@(posedge hclk) disable iff (!hresetn)
		!pwr_bit |=> !lo_ctl.synth_power)
		else $error("power bit clear did not stop the synth");

	a_lo_dir: assert property (@(posedge hclk) disable iff (!hresetn)
		lo_ctl.lo_port_oe |-> $past(sel_s && pwr_bit &&
		(drvpin_s || drv_bit)))
		else $error("LO port driven without its conditions");

	a_bus_okay: assert property (@(posedge hclk) disable iff (!hresetn)
		hreadyout && !hresp)
		else $error("bus answer not ready and OKAY");

	// The strobe pin takes two stages, then one edge-detect stage.
	sequence seq_strobe_pin_rise;
		sync1[4] && !sync2[4];
	endsequence

	// A rise seen by the first stage must become one detected edge.
	a_strobe_edge: assert property (
		@(posedge hclk) disable iff (!hresetn)
		seq_strobe_pin_rise |=> strobe_rise)
		else $error("strobe rise was not detected after the synchroniser");

	// A counted load moves the count on by exactly one.
	a_load_count: assert property (
		@(posedge hclk) disable iff (!hresetn)
		seq_strobe_rise |=> load_count == $past(load_count) + 16'h0001)
		else $error("load count did not step by one");

	// Without a load the mode and monitor bits must not move.
	a_regs_quiet: assert property (
		@(posedge hclk) disable iff (!hresetn)
		!load_en |=> $stable(pwr_bit) && $stable(drv_bit) &&
		$stable(mon_sel))
		else $error("stored register changed without a load");

	// A bus write to the control word lands in its data phase.
	a_ctrl_write: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(wr_pend && wr_addr == `SLP_ADDR_CTRL) |=> ctrl == $past(hwdata))
		else $error("control write did not land");

	// A status read returns the count held in its address phase.
	a_status_count: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(addr_ok && !hwrite && haddr == `SLP_ADDR_STATUS) |=>
		hrdata[15:0] == $past(load_count))
		else $error("status read returned the wrong count");

	// With the select pin low the LO pins are inputs.
	a_lo_port_in: assert property (
		@(posedge hclk) disable iff (!hresetn)
		!sel_s |=> !lo_ctl.lo_port_oe)
		else $error("LO port driven with select pin low");

	// Select, power and either drive source turn the LO pins to outputs.
	a_lo_port_out: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(sel_s && pwr_bit && (drvpin_s || drv_bit)) |=> lo_ctl.lo_port_oe)
		else $error("LO port not driven with its conditions met");

endmodule : slp_load_port

// file: src/slp_params.svh
// Constants of the serial register load port: offsets, fields, resets.
// Assumes inclusion by slp_pkg, the load port module and the bench.
`ifndef SLP_PARAMS_SVH
`define SLP_PARAMS_SVH

// ****************************************************************
// Serial word layout
// ****************************************************************
`define SLP_WORD_BITS      24
`define SLP_CTRL_BITS      3
`define SLP_DATA_BITS      21
`define SLP_NUM_REGS       8

// ****************************************************************
// Fields inside the stored data part (word bit minus three)
// ****************************************************************
`define SLP_PWR_REG        3'h5
`define SLP_PWR_BIT        3
`define SLP_DRV_BIT        0
`define SLP_MON_REG        3'h7
`define SLP_MON_BIT        0
`define SLP_REG5_RESET     21'h000008
`define SLP_REGX_RESET     21'h000000

// ****************************************************************
// Bus map, byte addresses
// ****************************************************************
`define SLP_ADDR_REG0      8'h00
`define SLP_ADDR_STATUS    8'h20
`define SLP_ADDR_CTRL      8'h24
`define SLP_CTRL_RESET     32'h00000001
`define SLP_HTRANS_NONSEQ  2'h2

`endif

// file: src/slp_pkg.sv
// Types of the serial register load port.
// Assumes slp_params.svh sits beside it in the include path.
`include "slp_params.svh"

package slp_pkg;

	// One stored register: the word without its three select bits.
	typedef logic [`SLP_DATA_BITS-1:0] slp_data_t;

	// Drive of the local oscillator path.
	typedef struct packed {
		logic synth_power;   // Internal synthesizer powered.
		logic lo_internal;   // Mixer fed from the synthesizer.
		logic lo_port_oe;    // LO port pins driven out.
	} slp_lo_t;

endpackage : slp_pkg

// file: bench/slp_ctl_model.sv
// Serial host model that drives the three-wire load port.
// Assumes the bench calls send and waits for it to return.
`timescale 1ns/10ps

module slp_ctl_model (
	output logic sclk,        // Link clock, idle low.
	output logic sdata,       // Serial data.
	output logic load_strobe  // Load pulse.
);
	// Between frames the clock stands still.
	initial begin
		sclk = 1'b0;
		sdata = 1'b0;
		load_strobe = 1'b0;
	end

	// One frame of n bits, top bit first, then a load pulse.
	task automatic send(input logic [31:0] w, input int n);
		for (int i = n - 1; i >= 0; i--) begin
			sdata = w[i];
			#12 sclk = 1'b1;
			#25 sclk = 1'b0;  // A 50 ns period stays at 20 MHz.
			#13;
		end
		// Data is inverted so the port cannot rely on a stale last bit.
		sdata = ~sdata;
		#10 load_strobe = 1'b1;
		#40 load_strobe = 1'b0;  // Long pulse lets the bus side sync it.
		#20;
	endtask : send
endmodule : slp_ctl_model

// file: bench/serial_register_load_port_test.sv
// Self-checking bench of the load port: bus reads, serial loads, LO pins.
// Assumes the serial host model and the port's package are compiled first.
`timescale 1ns/10ps
`include "slp_params.svh"

module serial_register_load_port_test;
	import slp_pkg::*;
	logic        hclk, hresetn, hwrite, hreadyout, hresp, mon, r;
	logic        sclk, sdata, load_strobe, synth_select, drv_pin;
	logic        ref_signal, lock_detect;
	logic [7:0]  haddr;
	logic [1:0]  htrans;
	logic [31:0] hwdata, hrdata, rd, w;
	slp_lo_t     lo_ctl;
	slp_data_t   shadow [8];
	int          error_cnt, samples_checked, cycles, exp_cnt;

	slp_load_port i_slp_load_port (.hclk(hclk), .hresetn(hresetn),
		.hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .sclk(sclk), .sdata(sdata),
		.load_strobe(load_strobe), .synth_select(synth_select),
		.lo_output_driver_pin(drv_pin), .ref_signal(ref_signal),
		.lock_detect(lock_detect), .selectable_monitor_out(mon),
		.lo_ctl(lo_ctl));
	slp_ctl_model i_slp_ctl_model (.sclk(sclk), .sdata(sdata),
		.load_strobe(load_strobe));

	// Clock and a hang limit well above the expected run of ~5000 cycles.
	always #4 hclk = ~hclk;
	always @(posedge hclk) begin
		cycles++;
		if (cycles == 10000) begin
			error_cnt++;
			conclude();
		end
	end

	task automatic chk_word(input string nm, input logic [31:0] e, g);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask : chk_word

	task automatic chk_lo(input string nm, input slp_lo_t e, g);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected %s: expected %b seen %b", nm, e, g);
		end
	endtask : chk_lo

	// One single transfer; the address phase is held until hready.
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] wd);
		@(posedge hclk);
		htrans <= `SLP_HTRANS_NONSEQ;
		haddr <= a;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : bus

	// LO path expected from the pins and the stored power and drive bits.
	function automatic slp_lo_t exp_lo(logic s, logic p, slp_data_t d);
		logic on;
		on = s & d[`SLP_PWR_BIT];
		return '{on, on, on & (p | d[`SLP_DRV_BIT])};
	endfunction : exp_lo

	task automatic load(input logic [2:0] k, input slp_data_t d);
		i_slp_ctl_model.send({8'ha5, d, k}, 24);
		shadow[k] = d;
		exp_cnt++;
	endtask : load

	task automatic check_regs();
		for (int k = 0; k < 8; k++) begin
			bus(1'b0, 8'(4 * k), 32'h0);
			chk_word("register", {11'h0, shadow[k]}, rd);
		end
		bus(1'b0, `SLP_ADDR_STATUS, 32'h0);
		chk_word("count", 32'(exp_cnt[15:0]), {16'h0, rd[15:0]});
	endtask : check_regs

	task automatic conclude();
		$display("checked %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : conclude

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		{hclk, hresetn, hwrite, htrans, haddr, hwdata} = '0;
		{drv_pin, ref_signal, lock_detect} = '0;
		synth_select = 1'b1;
		void'($urandom(32'hc591));
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		foreach (shadow[k]) shadow[k] = `SLP_REGX_RESET;
		shadow[5] = `SLP_REG5_RESET;
		check_regs();
		bus(1'b0, `SLP_ADDR_CTRL, 32'h0);
		chk_word("ctrl", `SLP_CTRL_RESET, rd);
		chk_lo("lo", exp_lo(1'b1, 1'b0, shadow[5]), lo_ctl);
		$display("test reset done");
		for (int k = 0; k < 8; k++) load(3'(k), slp_data_t'($urandom));
		check_regs();
		$display("test random loads done");
		w = $urandom;
		w[2:0] = 3'h2;
		i_slp_ctl_model.send(w, 32);
		shadow[2] = w[23:3];
		exp_cnt++;
		check_regs();
		$display("test overlong word done");
		bus(1'b1, `SLP_ADDR_CTRL, 32'h0);
		i_slp_ctl_model.send(~w, 24);
		bus(1'b1, `SLP_ADDR_CTRL, 32'h1);
		check_regs();
		$display("test loads disabled done");
		for (int m = 0; m < 16; m++) begin
			load(3'h5, slp_data_t'({m[1], 2'b0, m[0]}));
			@(posedge hclk);
			synth_select <= m[2];
			drv_pin <= m[3];
			repeat (6) @(posedge hclk);
			chk_lo("lo", exp_lo(m[2], m[3], shadow[5]), lo_ctl);
			bus(1'b0, `SLP_ADDR_STATUS, 32'h0);
			chk_word("status", {27'h0, exp_lo(m[2], m[3], shadow[5]), m[2],
				m[3]}, {27'h0, rd[20:16]});
		end
		$display("test lo selection done");
		for (int m = 0; m < 4; m++) begin
			load(3'h7, slp_data_t'(m[0]));
			r = 1'($urandom);
			@(posedge hclk);
			ref_signal <= r;
			lock_detect <= ~r;
			repeat (6) @(posedge hclk);
			chk_word("monitor", {31'h0, m[0] ? ~r : r}, {31'h0, mon});
		end
		$display("test monitor done");
		bus(1'b0, 8'h28, 32'h0);
		chk_word("unmapped", 32'h0, rd);
		$display("test unmapped done");
		conclude();
	end
endmodule : serial_register_load_port_test
